// ==== cam_decode.sv ====
// operand fetch and effective address for an 8-bit core
// assumes memory answers a held request with ack and data in one cycle
`default_nettype none
module cam_decode (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // instruction from the opcode stage
   input wire logic i_start,
   input wire logic [15:0] i_pc,
   input wire cam_pkg::cam_mode_t i_mode,
   input wire cam_pkg::cam_grp_t i_group,
   input wire cam_pkg::cam_inh_t i_inh_op,
   input wire logic i_sel_y,
   input wire logic [7:0] i_idx_x,
   input wire logic [7:0] i_idx_y,
   // memory port
   output logic o_mem_req,
   output logic [15:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_data,
   // results
   output logic o_busy,
   output logic o_done,
   output logic o_refused,
   output logic [1:0] o_len,
   output logic [15:0] o_ea,
   output logic [7:0] o_imm,
   output logic [15:0] o_next_pc,
   output logic [1:0] o_irq_level
);
   import cam_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // bytes that follow the opcode
   function automatic logic [1:0] opnd_bytes(input cam_mode_t m);
      case (m)
         CAM_INH, CAM_IDX_0: opnd_bytes = CNT_ZERO;
         CAM_DIR_L, CAM_IDX_L: opnd_bytes = CNT_TWO;
         default: opnd_bytes = CNT_ONE;
      endcase
   endfunction

   // pointer bytes read after the pointer address
   function automatic logic [1:0] ptr_bytes(input cam_mode_t m);
      case (m)
         CAM_IND_S, CAM_IIX_S: ptr_bytes = CNT_ONE;
         CAM_IND_L, CAM_IIX_L: ptr_bytes = CNT_TWO;
         default: ptr_bytes = CNT_ZERO;
      endcase
   endfunction

   function automatic logic is_long(input cam_mode_t m);
      is_long = (m == CAM_DIR_L) || (m == CAM_IDX_L) || (m == CAM_IND_L) || (m == CAM_IIX_L);
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_OPND = 4'b0010,
      S_PTR = 4'b0100,
      S_CALC = 4'b1000
   } cam_state_t;

   cam_state_t st_q;
   cam_mode_t mode_q;
   cam_inh_t inh_q;
   logic [1:0] cnt_q;
   logic [1:0] pcnt_q;
   logic [15:0] fa_q;
   logic [15:0] w_q;
   logic [15:0] pc_q;
   logic [7:0] idx_q;
   logic [1:0] len_q;
   logic refuse_q;
   logic done_q;
   logic refused_q;
   logic [15:0] ea_q;
   logic [15:0] npc_q;
   logic [7:0] imm_q;
   logic [1:0] irq_q;
   logic take;
   logic start_refuse;

   cam_ea_if ea_if ();

   // long forms only for the groups that own them
   assign start_refuse = (i_group != CAM_GRP_LONG_OK) && is_long(i_mode);
   assign take = i_mem_ack && o_mem_req;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // refused forms fetch nothing, so no stray bus cycles
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= S_IDLE;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (i_start) begin
                  if (start_refuse || opnd_bytes(i_mode) == CNT_ZERO) begin
                     st_q <= S_CALC;
                  end else begin
                     st_q <= S_OPND;
                  end
               end
            end
            S_OPND: begin
               if (take && cnt_q == CNT_ONE) begin
                  st_q <= (pcnt_q != CNT_ZERO) ? S_PTR : S_CALC;
               end
            end
            S_PTR: begin
               if (take && pcnt_q == CNT_ONE) begin
                  st_q <= S_CALC;
               end
            end
            S_CALC: st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // capture of the instruction context
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_q <= CAM_INH;
         inh_q <= CAM_OP_PLAIN;
         pc_q <= 16'h0000;
         idx_q <= 8'h00;
         len_q <= OPC_LEN;
         refuse_q <= 1'b0;
      end else if (st_q == S_IDLE && i_start) begin
         mode_q <= i_mode;
         inh_q <= i_inh_op;
         pc_q <= i_pc;
         idx_q <= i_sel_y ? i_idx_y : i_idx_x;
         len_q <= OPC_LEN + opnd_bytes(i_mode);
         refuse_q <= start_refuse;
      end
   end

   // byte counters
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= CNT_ZERO;
         pcnt_q <= CNT_ZERO;
      end else if (st_q == S_IDLE && i_start) begin
         cnt_q <= opnd_bytes(i_mode);
         pcnt_q <= ptr_bytes(i_mode);
      end else if (take && st_q == S_OPND) begin
         cnt_q <= cnt_q - CNT_ONE;
      end else if (take && st_q == S_PTR) begin
         pcnt_q <= pcnt_q - CNT_ONE;
      end
   end

   // fetch address: operand bytes follow the opcode, pointer sits in page zero
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fa_q <= 16'h0000;
      end else if (st_q == S_IDLE && i_start) begin
         fa_q <= i_pc + 16'h0001;
      end else if (take && st_q == S_OPND && cnt_q == CNT_ONE && pcnt_q != CNT_ZERO) begin
         fa_q <= {PAGE0_HI, i_mem_data};
      end else if (take) begin
         fa_q <= fa_q + 16'h0001;
      end
   end

   // fetched bytes, high byte of a word first
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         w_q <= 16'h0000;
      end else if (st_q == S_IDLE && i_start) begin
         w_q <= 16'h0000;
      end else if (take) begin
         w_q <= {w_q[7:0], i_mem_data};
      end
   end

   // ----------------------------------------
   // results
   // ----------------------------------------
   assign ea_if.mode = mode_q;
   assign ea_if.word = w_q;
   assign ea_if.index = idx_q;
   assign ea_if.pc = pc_q;

   cam_ea_calc u_calc (
      .ea_if(ea_if)
   );

   // ea, next pc and imm latched once, so they hold until the next accepted instruction ends; done and refused pulse for one cycle
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         done_q <= 1'b0;
         refused_q <= 1'b0;
         ea_q <= 16'h0000;
         npc_q <= 16'h0000;
         imm_q <= 8'h00;
      end else begin
         done_q <= (st_q == S_CALC);
         refused_q <= (st_q == S_CALC) && refuse_q;
         if (st_q == S_CALC && !refuse_q) begin
            ea_q <= ea_if.ea;
            npc_q <= (mode_q == CAM_REL) ? ea_if.next_pc : pc_q + {14'h0000, len_q};
            imm_q <= w_q[7:0];
         end
      end
   end

   // interrupt mask level
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_q <= IRQ_LVL_RST;
      end else if (st_q == S_CALC && mode_q == CAM_INH) begin
         if (inh_q == CAM_OP_SET_IRQ_MASK) begin
            irq_q <= IRQ_LVL_SET;
         end else if (inh_q == CAM_OP_CLR_IRQ_MASK) begin
            irq_q <= IRQ_LVL_CLR;
         end
      end
   end

   // outputs
   assign o_mem_req = (st_q == S_OPND) || (st_q == S_PTR);
   assign o_mem_addr = fa_q;
   assign o_busy = (st_q != S_IDLE);
   assign o_done = done_q;
   assign o_refused = refused_q;
   assign o_len = len_q;
   assign o_ea = ea_q;
   assign o_imm = imm_q;
   assign o_next_pc = npc_q;
   assign o_irq_level = irq_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   chk_inh_one_byte: assert property (
      (st_q == S_IDLE && i_start && i_mode == CAM_INH) |=> (st_q == S_CALC) ##1 (o_done && o_len == 2'h1))
      else $error("inherent not one byte");

   chk_imm_two_bytes: assert property (
      (o_done && mode_q == CAM_IMM) |-> (o_len == 2'h2 && o_imm == w_q[7:0]))
      else $error("immediate length wrong");

   chk_dir_page_zero: assert property (
      (o_done && mode_q == CAM_DIR_S) |-> (o_ea[15:8] == 8'h00 && o_len == 2'h2))
      else $error("short direct left page zero");

   chk_long_word_len: assert property (
      (o_done && !o_refused && (mode_q == CAM_DIR_L || mode_q == CAM_IDX_L)) |-> o_len == 2'h3)
      else $error("long form length wrong");

   chk_idx_short_sum: assert property (
      (o_done && mode_q == CAM_IDX_S) |-> o_ea == ({8'h00, w_q[7:0]} + {8'h00, idx_q}))
      else $error("short indexed sum wrong");

   chk_ptr_page_zero: assert property (
      (st_q == S_PTR) |-> o_mem_addr[15:9] == 7'h00)
      else $error("pointer read outside page zero");

   chk_rel_target: assert property (
      (o_done && mode_q == CAM_REL) |-> o_next_pc == pc_q + 16'h0002 + {{8{w_q[7]}}, w_q[7:0]})
      else $error("relative target wrong");

   chk_set_mask: assert property (
      (st_q == S_CALC && mode_q == CAM_INH && inh_q == CAM_OP_SET_IRQ_MASK) |=> o_irq_level == 2'h3)
      else $error("mask not raised to 3");

   chk_clr_mask: assert property (
      (st_q == S_CALC && mode_q == CAM_INH && inh_q == CAM_OP_CLR_IRQ_MASK) |=> o_irq_level == 2'h0)
      else $error("mask not lowered to 0");

   chk_short_only: assert property (
      (st_q == S_IDLE && i_start && i_group == CAM_GRP_SHORT_ONLY && is_long(i_mode))
      |=> !o_mem_req ##1 o_refused)
      else $error("long form not refused");

   chk_idx0_no_fetch: assert property (
      (st_q == S_IDLE && i_start && i_mode == CAM_IDX_0) |=> (st_q == S_CALC && !o_mem_req))
      else $error("indexed without offset fetched a byte");

   chk_idx0_ea_index: assert property (
      (o_done && mode_q == CAM_IDX_0) |-> (o_ea == {8'h00, idx_q} && o_len == 2'h1))
      else $error("indexed without offset address wrong");

   chk_rel_offset_addr: assert property (
      (st_q == S_OPND && mode_q == CAM_REL) |-> o_mem_addr == pc_q + 16'h0001)
      else $error("relative offset not after opcode");

   chk_long_accepted: assert property (
      (st_q == S_IDLE && i_start && i_group == CAM_GRP_LONG_OK && is_long(i_mode)) |=> (o_mem_req && !o_refused))
      else $error("long form refused for a long group");

   chk_long_dir_word: assert property (
      (o_done && !o_refused && mode_q == CAM_DIR_L) |-> o_ea == w_q)
      else $error("long direct address wrong");

   chk_ind_short_page: assert property (
      (o_done && mode_q == CAM_IND_S) |-> o_ea[15:8] == 8'h00)
      else $error("short indirect left page zero");

   chk_iix_short_reach: assert property (
      (o_done && mode_q == CAM_IIX_S) |-> o_ea[15:9] == 7'h00)
      else $error("short indirect indexed beyond 1FE");

   chk_refuse_keeps_ea: assert property (
      (o_done && o_refused) |-> o_ea == $past(o_ea))
      else $error("refused form changed the address");

   cov_long_ind_idx: cover property (o_done && mode_q == CAM_IIX_L);
   cov_rel_back: cover property (o_done && mode_q == CAM_REL && w_q[7]);
   cov_refused: cover property (o_refused);
   cov_stall: cover property (o_mem_req && !i_mem_ack ##1 take);
endmodule
`default_nettype wire

// ==== cam_ea_calc.sv ====
// effective address and branch target arithmetic
// assumes word holds fetched bytes, high byte first, short values in [7:0]
`default_nettype none
module cam_ea_calc (
   cam_ea_if.calc ea_if
);
   import cam_pkg::*;

   logic [8:0] short_sum;
   logic [15:0] sext_off;

   // short sums keep the carry so reach runs to 1FE
   assign short_sum = {1'b0, ea_if.word[7:0]} + {1'b0, ea_if.index};
   assign sext_off = {{8{ea_if.word[7]}}, ea_if.word[7:0]};

   // mode select, unsigned wrap for the long sums
   always_comb begin
      case (ea_if.mode)
         CAM_DIR_S, CAM_IND_S: ea_if.ea = {PAGE0_HI, ea_if.word[7:0]};
         CAM_DIR_L, CAM_IND_L: ea_if.ea = ea_if.word;
         CAM_IDX_0: ea_if.ea = {PAGE0_HI, ea_if.index};
         CAM_IDX_S, CAM_IIX_S: ea_if.ea = {7'h00, short_sum};
         CAM_IDX_L, CAM_IIX_L: ea_if.ea = ea_if.word + {PAGE0_HI, ea_if.index};
         default: ea_if.ea = 16'h0000;
      endcase
   end

   // target counts from the byte after the whole branch
   assign ea_if.next_pc = ea_if.pc + REL_LEN + sext_off;
endmodule
`default_nettype wire

// ==== cam_ea_if.sv ====
// carrier between the decoder and its address calculator
// assumes both ends sit on the same clock; mode, word, index and pc come from registers, ea and next_pc are combinational
`default_nettype none
interface cam_ea_if;
   import cam_pkg::*;
   cam_mode_t mode;
   logic [15:0] word;
   logic [7:0] index;
   logic [15:0] pc;
   logic [15:0] ea;
   logic [15:0] next_pc;
   modport calc (input mode, input word, input index, input pc, output ea, output next_pc);
   modport user (output mode, output word, output index, output pc, input ea, input next_pc);
endinterface
`default_nettype wire

// ==== cam_mem_model.sv ====
// memory partner for the decoder: byte array answering with ack
// assumes request and address stay put until ack, same clock as decoder
`default_nettype none
module cam_mem_model (
   // clock and stall control
   input wire logic i_sys_clk,
   input wire logic i_slow,
   // memory port
   input wire logic i_mem_req,
   input wire logic [15:0] i_mem_addr,
   output logic o_mem_ack,
   output logic [7:0] o_mem_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic [15:0] log_q[$];
   logic ack_en_q = 1'h1;
   // per-cycle stall draw; the log lets the bench see fetch order and count
   always @(posedge i_sys_clk) begin
      if (o_mem_ack) log_q.push_back(i_mem_addr);
      ack_en_q <= i_slow ? 1'($urandom % 2) : 1'h1;
   end
   // an unanswered cycle shows the inverse, so stale data cannot pass
   assign o_mem_ack = i_mem_req & ack_en_q;
   assign o_mem_data = o_mem_ack ? mem[i_mem_addr] : ~mem[i_mem_addr];
endmodule
`default_nettype wire

// ==== cam_pkg.sv ====
// package for the addressing-mode decoder: modes, groups, widths, constants
// assumes the opcode itself has already been fetched and classified upstream
`default_nettype none
package cam_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [1:0] OPC_LEN = 2'h1;
   localparam logic [15:0] REL_LEN = 16'h0002;
   localparam logic [7:0] PAGE0_HI = 8'h00;
   localparam logic [1:0] IRQ_LVL_SET = 2'h3;
   localparam logic [1:0] IRQ_LVL_CLR = 2'h0;
   localparam logic [1:0] IRQ_LVL_RST = 2'h3;
   localparam logic [1:0] CNT_ZERO = 2'h0;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [1:0] CNT_TWO = 2'h2;

   // addressing modes
   typedef enum logic [3:0] {
      CAM_INH = 4'h0, CAM_IMM = 4'h1, CAM_DIR_S = 4'h2, CAM_DIR_L = 4'h3,
      CAM_IDX_0 = 4'h4, CAM_IDX_S = 4'h5, CAM_IDX_L = 4'h6, CAM_IND_S = 4'h7,
      CAM_IND_L = 4'h8, CAM_IIX_S = 4'h9, CAM_IIX_L = 4'hA, CAM_REL = 4'hB
   } cam_mode_t;

   // instruction groups as far as long forms are concerned
   typedef enum logic [1:0] {
      CAM_GRP_LONG_OK = 2'h0,
      CAM_GRP_SHORT_ONLY = 2'h1,
      CAM_GRP_OTHER = 2'h2
   } cam_grp_t;

   // inherent operations with a side effect here
   typedef enum logic [1:0] {
      CAM_OP_PLAIN = 2'h0,
      CAM_OP_SET_IRQ_MASK = 2'h1,
      CAM_OP_CLR_IRQ_MASK = 2'h2
   } cam_inh_t;
endpackage
`default_nettype wire

// ==== cpu_addressing_mode_decode_tb_top.sv ====
// self-checking bench for the addressing-mode decoder
// assumes cam_mem_model as memory and a 40 MHz clock
`default_nettype none
module cpu_addressing_mode_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cam_pkg::*;
   // ----------
   // signals
   // ----------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic start = 1'h0;
   logic sel_y = 1'h0;
   logic slow = 1'h0;
   logic [15:0] pc = '0;
   logic [7:0] ix = '0;
   logic [7:0] iy = '0;
   cam_mode_t mode = CAM_INH;
   cam_grp_t grp = CAM_GRP_LONG_OK;
   cam_inh_t inh = CAM_OP_PLAIN;
   logic req, ack, busy, done, refused;
   logic [15:0] maddr, ea, npc;
   logic [7:0] mdata, imm;
   logic [1:0] len, irq;
   int error_cnt = 0;
   int n_compared = 0;
   int e_ea = 0;
   int e_npc = 0;
   int e_irq = 3;
   bit ea_ok = 0;
   cam_mode_t lm[4] = '{CAM_DIR_L, CAM_IDX_L, CAM_IND_L, CAM_IIX_L};

   // 25 ns period
   always #12.5 clk = ~clk;

   cam_decode dut (
      .i_sys_clk(clk), .i_rst(rst), .i_start(start), .i_pc(pc), .i_mode(mode), .i_group(grp),
      .i_inh_op(inh), .i_sel_y(sel_y), .i_idx_x(ix), .i_idx_y(iy), .o_mem_req(req), .o_mem_addr(maddr),
      .i_mem_ack(ack), .i_mem_data(mdata), .o_busy(busy), .o_done(done), .o_refused(refused), .o_len(len),
      .o_ea(ea), .o_imm(imm), .o_next_pc(npc), .o_irq_level(irq));

   cam_mem_model u_mem (.i_sys_clk(clk), .i_slow(slow), .i_mem_req(req), .i_mem_addr(maddr),
      .o_mem_ack(ack), .o_mem_data(mdata));

   task automatic check(string what, logic [15:0] seen, int exp);
      n_compared++;
      if (seen !== 16'(exp)) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, 16'(exp), seen);
      end
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic endtest(string t);
      $display("test %s ends, mismatches %0d", t, error_cnt);
   endtask

   function automatic int mb(int a);
      return int'(u_mem.mem[a & 16'hFFFF]);
   endfunction

   // one instruction: reference model, drive, wait for done, compare
   task automatic run(cam_mode_t m, cam_grp_t g, cam_inh_t op, int p, bit sy, int x, int y);
      int b1, b2, ptr, idx, ln, xe, k;
      bit rf;
      int fq[$];
      p = p & 16'hFFFF;
      idx = (sy ? y : x) & 8'hFF;
      b1 = mb(p + 1);
      b2 = mb(p + 2);
      rf = m inside {CAM_DIR_L, CAM_IDX_L, CAM_IND_L, CAM_IIX_L} && g != CAM_GRP_LONG_OK;
      ln = m inside {CAM_INH, CAM_IDX_0} ? 1 : m inside {CAM_DIR_L, CAM_IDX_L} ? 3 : 2;
      ptr = m inside {CAM_IND_L, CAM_IIX_L} ? mb(b1) * 256 + mb(b1 + 1) : mb(b1);
      for (k = 1; k < ln && !rf; k++) fq.push_back((p + k) & 16'hFFFF);
      if (!rf && m inside {CAM_IND_S, CAM_IIX_S, CAM_IND_L, CAM_IIX_L}) fq.push_back(b1);
      if (!rf && m inside {CAM_IND_L, CAM_IIX_L}) fq.push_back(b1 + 1);
      case (m)
         CAM_DIR_S: xe = b1;
         CAM_DIR_L: xe = b1 * 256 + b2;
         CAM_IDX_0: xe = idx;
         CAM_IDX_S: xe = b1 + idx;
         CAM_IDX_L: xe = (b1 * 256 + b2 + idx) & 16'hFFFF;
         CAM_IND_S, CAM_IND_L: xe = ptr;
         CAM_IIX_S, CAM_IIX_L: xe = (ptr + idx) & 16'hFFFF;
         default: xe = -1;
      endcase
      u_mem.log_q.delete();
      @(posedge clk);
      start <= 1'h1;
      mode <= m;
      grp <= g;
      inh <= op;
      pc <= 16'(p);
      sel_y <= sy;
      ix <= 8'(x);
      iy <= 8'(y);
      // held over the first busy edge too, where it must be ignored
      repeat (2) @(posedge clk);
      start <= 1'h0;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (done !== 1'h1 && k < 100);
      check("done", done, 1);
      check("refused", refused, rf);
      if (m == CAM_INH && op != CAM_OP_PLAIN) e_irq = op == CAM_OP_SET_IRQ_MASK ? 3 : 0;
      check("irq level", irq, e_irq);
      if (!rf) begin
         e_npc = m == CAM_REL ? (p + 2 + b1 - (b1 > 127 ? 256 : 0)) & 16'hFFFF : (p + ln) & 16'hFFFF;
         check("len", len, ln);
         if (m == CAM_IMM) check("imm", imm, b1);
         ea_ok = xe >= 0;
         e_ea = xe;
      end
      check("next pc", npc, e_npc);
      if (ea_ok) check("ea", ea, e_ea);
      check("fetches", 16'(u_mem.log_q.size()), fq.size());
      foreach (fq[i]) if (i < u_mem.log_q.size()) check("fetch addr", u_mem.log_q[i], fq[i]);
   endtask

   // main sequence
   initial begin
      void'($urandom(32'hB58D53F9));
      for (int a = 0; a < 65536; a++) u_mem.mem[a] = 8'($urandom);
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      check("busy", busy, 0);
      check("done", done, 0);
      check("mem req", req, 0);
      check("len", len, 1);
      check("irq level", irq, 3);
      endtest("reset");
      // every mode with long forms allowed; mask cleared, then plain, then set
      for (int i = 0; i < 36; i++) run(cam_mode_t'(i % 12), CAM_GRP_LONG_OK, cam_inh_t'((i / 12 + 2) % 3),
         $urandom, 1'($urandom), $urandom, $urandom);
      endtest("modes");
      // long forms from restricted groups, short form first so ea is known
      for (int i = 0; i < 8; i++) begin
         run(CAM_DIR_S, CAM_GRP_SHORT_ONLY, CAM_OP_PLAIN, $urandom, 0, 0, 0);
         run(lm[i % 4], cam_grp_t'(1 + i / 4), CAM_OP_PLAIN, $urandom, 0, 0, 0);
      end
      endtest("refuse");
      // boundary sums, page-crossing pointer word, branch wrap both ways
      u_mem.mem[16'h2001] = 8'hFF;
      run(CAM_IDX_S, CAM_GRP_LONG_OK, CAM_OP_PLAIN, 16'h2000, 0, 8'hFF, 0);
      u_mem.mem[16'h2011] = 8'h80;
      u_mem.mem[16'h0080] = 8'hFF;
      run(CAM_IIX_S, CAM_GRP_LONG_OK, CAM_OP_PLAIN, 16'h2010, 1, 0, 8'hFF);
      u_mem.mem[16'h2021] = 8'hFF;
      run(CAM_IND_L, CAM_GRP_LONG_OK, CAM_OP_PLAIN, 16'h2020, 0, 0, 0);
      u_mem.mem[16'h0001] = 8'h80;
      run(CAM_REL, CAM_GRP_OTHER, CAM_OP_PLAIN, 16'h0000, 0, 0, 0);
      u_mem.mem[16'hFFF1] = 8'h7F;
      run(CAM_REL, CAM_GRP_OTHER, CAM_OP_PLAIN, 16'hFFF0, 0, 0, 0);
      u_mem.mem[16'h3001] = 8'h00;
      run(CAM_REL, CAM_GRP_OTHER, CAM_OP_PLAIN, 16'h3000, 0, 0, 0);
      endtest("bounds");
      // memory stalls at random, every mode in turn, all other inputs random
      slow <= 1'h1;
      for (int i = 0; i < 36; i++) run(cam_mode_t'(i % 12), cam_grp_t'($urandom % 3), cam_inh_t'($urandom % 3),
         $urandom, 1'($urandom), $urandom, $urandom);
      slow <= 1'h0;
      endtest("stall");
      conclude();
   end

   // watchdog: 94 runs of under 100 cycles each fit well inside this
   initial begin
      #1_000_000;
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
